// ### hdl/pcg_config.sv
// Purpose: options, external clock and power-good configuration bank with its effects
// Assumes: register port driven by the serial interface logic on clock_i
// Notes: only the enable and external clock pins pass a two-stage synchroniser before use
// Behaviour
// R1 - startup range bit picks 0.5 ms or 1 ms steps
// R2 - shutdown range bit picks 0.5 ms or 1 ms steps
// R3 - options bit 4 makes clock pin general output 2 or clock input
// R4 - options bit 3 drives clock pin pull-down in either function
// R5 - options bit 2 drives enable pin pull-down
// R6 - options bit 1 selects 125 or 137 degree warning threshold
// R7 - options bit 0 enables spread spectrum
// R8 - pll enable low forces internal oscillator, pll off
// R9 - pll enable high runs pll, uses external clock when present; the code also needs options bit 4 set and a frequency code up to 0x17
// R10 - pll enabled: flag event on external clock appear and disappear
// R11 - host writes zero to external clock reserved bit 5
// R12 - frequency code n means n+1 MHz; codes from 0x18 reserved
// R13 - polarity bit chooses high or low valid power-good level
// R14 - output type bit chooses push-pull or open-drain drive
// R15 - linear window bit adds overvoltage check for linear regulators
// R16 - buck window bit adds overvoltage check for bucks
// R17 - bits 3..0 include each source in power-good monitoring
// R18 - delay counts code steps from enable edge
// R19 - mode bit selects gated or continuous power-good operation
// R20 - latch interrupt on power-good active to inactive, write one clears
// R21 - power-good valid only while every enabled source is in window
// R22 - fields read and write; reserved bits reset to zero
`timescale 1ns/1ps
`default_nettype none
module pcg_config
	import pcg_pkg::*;
#(
	parameter int unsigned SHORT_CYC = STEP_SHORT_CYC,
	parameter int unsigned LONG_CYC = STEP_LONG_CYC
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_ack_o,
	input wire logic enable_pin_i,
	input wire logic ext_clk_present_i,
	input wire logic [3:0] source_uv_ok_i,
	input wire logic [3:0] source_ov_ok_i,
	input wire logic [3:0] startup_code_i,
	input wire logic [3:0] shutdown_code_i,
	input wire logic general_output_2_level_i,
	output logic startup_done_o,
	output logic shutdown_done_o,
	output logic clock_pin_is_input_o,
	output logic clock_pin_pulldown_o,
	output logic enable_pin_pulldown_o,
	output logic thermal_warning_threshold_o,
	output logic spread_spectrum_enable_o,
	output logic pll_enable_o,
	output logic use_external_clock_o,
	output logic [4:0] external_clock_frequency_code_o,
	output logic ext_clock_event_o,
	output logic power_good_out_o,
	output logic power_good_out_oe_n_o,
	output logic power_good_operating_mode_o,
	output logic power_good_fall_interrupt_o
);
	logic [7:0] opt_ff, nxt_opt;
	logic [7:0] ext_ff, nxt_ext;
	logic [7:0] pgs_ff, nxt_pgs;
	logic [7:0] pgm_ff, nxt_pgm;
	logic pgi_ff, nxt_pgi;
	logic [7:0] rdata_ff, nxt_rdata;
	logic ack_ff, nxt_ack;
	logic [2:0] en_sync_ff, nxt_en_sync;
	logic [2:0] clk_sync_ff, nxt_clk_sync;
	logic valid_ff, nxt_valid;
	logic pg_pin_ff, nxt_pg_pin;
	logic pg_oe_n_ff, nxt_pg_oe_n;
	logic use_ext_ff, nxt_use_ext;
	logic ext_evt_ff, nxt_ext_evt;
	logic general_output_2_pd_ff, nxt_general_output_2_pd;
	logic [3:0] src_ok;
	logic all_ok;
	logic en_rise, en_fall;
	logic wr_opt, wr_ext, wr_pgs, wr_pgm, wr_pgi;

	// masked write keeps reserved bits at zero
	function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
		masked = d & m;
	endfunction

	// address decode
	always_comb
	begin
		wr_opt = 1'b0;
		wr_ext = 1'b0;
		wr_pgs = 1'b0;
		wr_pgm = 1'b0;
		wr_pgi = 1'b0;
		if (!reg_wr_i)
			wr_opt = 1'b0;
		else if (reg_addr_i == ADDR_OPTIONS)
			wr_opt = 1'b1;
		else if (reg_addr_i == ADDR_EXT_CLK)
			wr_ext = 1'b1;
		else if (reg_addr_i == ADDR_PG_SRC)
			wr_pgs = 1'b1;
		else if (reg_addr_i == ADDR_PG_MODE)
			wr_pgm = 1'b1;
		else if (reg_addr_i == ADDR_PG_INT)
			wr_pgi = 1'b1;
	end

	// per-source window check; overvoltage only counts when the window bit asks
	always_comb
	begin
		src_ok[0] = source_uv_ok_i[0] & (source_ov_ok_i[0] | ~pgs_ff[PGS_BUCK_WIN]); // R16
		src_ok[1] = source_uv_ok_i[1] & (source_ov_ok_i[1] | ~pgs_ff[PGS_BUCK_WIN]); // R16
		src_ok[2] = source_uv_ok_i[2] & (source_ov_ok_i[2] | ~pgs_ff[PGS_LIN_WIN]); // R15
		src_ok[3] = source_uv_ok_i[3] & (source_ov_ok_i[3] | ~pgs_ff[PGS_LIN_WIN]); // R15
		all_ok = &(src_ok | ~pgs_ff[3:0]); // R17 R21
	end

	assign en_rise = en_sync_ff[1] & ~en_sync_ff[2];
	assign en_fall = ~en_sync_ff[1] & en_sync_ff[2];

	// register bank, synchronisers and power-good logic
	always_comb
	begin
		nxt_opt = opt_ff;
		nxt_ext = ext_ff;
		nxt_pgs = pgs_ff;
		nxt_pgm = pgm_ff;
		nxt_pgi = pgi_ff;
		if (wr_opt)
			nxt_opt = masked(reg_wdata_i, OPT_WMASK); // R22
		if (wr_ext)
			nxt_ext = masked(reg_wdata_i, EXT_WMASK); // R11 R12
		if (wr_pgs)
			nxt_pgs = reg_wdata_i;
		if (wr_pgm)
			nxt_pgm = masked(reg_wdata_i, PGM_WMASK);
		nxt_en_sync = {en_sync_ff[1:0], enable_pin_i};
		nxt_clk_sync = {clk_sync_ff[1:0], ext_clk_present_i};
		nxt_valid = all_ok;
		// clear by writing one; a new fall in the same cycle wins
		if (wr_pgi && reg_wdata_i[PGI_BIT])
			nxt_pgi = 1'b0; // R20
		if (valid_ff && !all_ok)
			nxt_pgi = 1'b1; // R20
		// in gated mode the output follows only while enable is high
		if (pgm_ff[PGM_MODE] || en_sync_ff[1])
			nxt_pg_pin = valid_ff ^ pgs_ff[PGS_POL]; // R13 R19
		else
			nxt_pg_pin = pgs_ff[PGS_POL];
		// open drain releases the line for a high level
		nxt_pg_oe_n = pgs_ff[PGS_OD] & nxt_pg_pin; // R14
		nxt_use_ext = ext_ff[EXT_PLL_EN] & clk_sync_ff[1] & opt_ff[OPT_CLK_PIN_FUNC]
			& (ext_ff[4:0] <= EXT_FREQ_MAX); // R8 R9 R12
		nxt_ext_evt = ext_ff[EXT_PLL_EN] & (clk_sync_ff[1] ^ clk_sync_ff[2]); // R10
		nxt_general_output_2_pd = opt_ff[OPT_CLK_PIN_PD]; // R4
		nxt_ack = reg_rd_i | reg_wr_i;
		nxt_rdata = RESET_BYTE;
		if (!reg_rd_i)
			nxt_rdata = RESET_BYTE;
		else if (reg_addr_i == ADDR_OPTIONS)
			nxt_rdata = opt_ff;
		else if (reg_addr_i == ADDR_EXT_CLK)
			nxt_rdata = ext_ff;
		else if (reg_addr_i == ADDR_PG_SRC)
			nxt_rdata = pgs_ff;
		else if (reg_addr_i == ADDR_PG_MODE)
			nxt_rdata = pgm_ff;
		else if (reg_addr_i == ADDR_PG_INT)
			nxt_rdata = {pgi_ff, 7'h00};
	end

	// registers only
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			opt_ff <= RESET_BYTE;
			ext_ff <= RESET_BYTE;
			pgs_ff <= RESET_BYTE;
			pgm_ff <= RESET_BYTE;
			pgi_ff <= 1'b0;
			rdata_ff <= RESET_BYTE;
			ack_ff <= 1'b0;
			en_sync_ff <= 3'h0;
			clk_sync_ff <= 3'h0;
			valid_ff <= 1'b0;
			pg_pin_ff <= 1'b0;
			pg_oe_n_ff <= 1'b0;
			use_ext_ff <= 1'b0;
			ext_evt_ff <= 1'b0;
			general_output_2_pd_ff <= 1'b0;
		end
		else
		begin
			opt_ff <= nxt_opt;
			ext_ff <= nxt_ext;
			pgs_ff <= nxt_pgs;
			pgm_ff <= nxt_pgm;
			pgi_ff <= nxt_pgi;
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
			en_sync_ff <= nxt_en_sync;
			clk_sync_ff <= nxt_clk_sync;
			valid_ff <= nxt_valid;
			pg_pin_ff <= nxt_pg_pin;
			pg_oe_n_ff <= nxt_pg_oe_n;
			use_ext_ff <= nxt_use_ext;
			ext_evt_ff <= nxt_ext_evt;
			general_output_2_pd_ff <= nxt_general_output_2_pd;
		end
	end

	// startup timer from enable rising edge
	pcg_delay #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_startup
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.start_i(en_rise),
		.long_range_i(opt_ff[OPT_STARTUP_SEL]), // R1
		.code_i(startup_code_i),
		.done_o(startup_done_o)
	);

	// shutdown timer from enable falling edge
	pcg_delay #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_shutdown
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.start_i(en_fall),
		.long_range_i(opt_ff[OPT_SHUTDOWN_SEL]), // R2
		.code_i(shutdown_code_i),
		.done_o(shutdown_done_o)
	);

	// outputs straight from flip-flops
	assign reg_rdata_o = rdata_ff;
	assign reg_ack_o = ack_ff;
	assign clock_pin_is_input_o = opt_ff[OPT_CLK_PIN_FUNC]; // R3
	assign clock_pin_pulldown_o = general_output_2_pd_ff; // R4
	assign enable_pin_pulldown_o = opt_ff[OPT_EN_PIN_PD]; // R5
	assign thermal_warning_threshold_o = opt_ff[OPT_THERM_THRESH]; // R6
	assign spread_spectrum_enable_o = opt_ff[OPT_SPREAD]; // R7
	assign pll_enable_o = ext_ff[EXT_PLL_EN]; // R8 R9
	assign use_external_clock_o = use_ext_ff; // R9
	assign external_clock_frequency_code_o = ext_ff[4:0]; // R12
	assign ext_clock_event_o = ext_evt_ff; // R10
	assign power_good_out_o = pg_pin_ff;
	assign power_good_out_oe_n_o = pg_oe_n_ff;
	assign power_good_operating_mode_o = pgm_ff[PGM_MODE]; // R19
	assign power_good_fall_interrupt_o = pgi_ff; // R20
endmodule
`default_nettype wire

// ### hdl/pcg_delay.sv
// Purpose: one startup or shutdown delay timer
// Assumes: trigger is a one-cycle pulse on the core clock
// Notes: a code of zero raises done two cycles after the trigger
`timescale 1ns/1ps
`default_nettype none
module pcg_delay
	import pcg_pkg::*;
#(
	parameter int unsigned SHORT_CYC = STEP_SHORT_CYC,
	parameter int unsigned LONG_CYC = STEP_LONG_CYC
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic long_range_i,
	input wire logic [3:0] code_i,
	output logic done_o
);
	pcg_dly_state_type state_ff, nxt_state;
	logic [DLY_W-1:0] cnt_ff, nxt_cnt;
	logic [3:0] steps_ff, nxt_steps;
	logic done_ff, nxt_done;
	logic [DLY_W-1:0] step_len;

	// step length follows the range select
	assign step_len = long_range_i ? DLY_W'(LONG_CYC) : DLY_W'(SHORT_CYC); // R1 R2
	assign done_o = done_ff;

	// counts code steps of the selected length; a retrigger restarts
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_steps = steps_ff;
		nxt_done = 1'b0;
		if (start_i)
		begin
			nxt_steps = code_i; // R18
			nxt_cnt = '0;
			nxt_state = (code_i == 4'h0) ? DS_DONE : DS_RUN;
		end
		else
		begin
			case (state_ff)
				DS_RUN:
				begin
					if (cnt_ff == step_len - DLY_W'(1))
					begin
						nxt_cnt = '0;
						nxt_steps = steps_ff - 4'h1;
						if (steps_ff == 4'h1)
							nxt_state = DS_DONE;
					end
					else
						nxt_cnt = cnt_ff + DLY_W'(1);
				end
				DS_DONE:
				begin
					nxt_done = 1'b1;
					nxt_state = DS_IDLE;
				end
				default: nxt_state = DS_IDLE;
			endcase
		end
	end

	// registers only
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_ff <= DS_IDLE;
			cnt_ff <= '0;
			steps_ff <= 4'h0;
			done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			steps_ff <= nxt_steps;
			done_ff <= nxt_done;
		end
	end
endmodule
`default_nettype wire

// ### inc/pcg_pkg.sv
// Purpose: shared constants for the clock and power-good configuration bank
// Assumes: byte-wide registers reached over a simple internal register port
// Notes: delay step figures in microseconds; counts derive from the core clock rate
package pcg_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam logic [7:0] ADDR_OPTIONS = 8'h13;
	localparam logic [7:0] ADDR_EXT_CLK = 8'h14;
	localparam logic [7:0] ADDR_PG_SRC = 8'h15;
	localparam logic [7:0] ADDR_PG_MODE = 8'h16;
	localparam logic [7:0] ADDR_PG_INT = 8'h19;
	// options register fields
	localparam int OPT_STARTUP_SEL = 6;
	localparam int OPT_SHUTDOWN_SEL = 5;
	localparam int OPT_CLK_PIN_FUNC = 4;
	localparam int OPT_CLK_PIN_PD = 3;
	localparam int OPT_EN_PIN_PD = 2;
	localparam int OPT_THERM_THRESH = 1;
	localparam int OPT_SPREAD = 0;
	localparam logic [7:0] OPT_WMASK = 8'h7f;
	// external clock register fields
	localparam int EXT_PLL_EN = 6;
	localparam logic [7:0] EXT_WMASK = 8'h5f;
	localparam logic [4:0] EXT_FREQ_MAX = 5'h17;
	// power-good source, mode and interrupt fields
	localparam int PGS_POL = 7;
	localparam int PGS_OD = 6;
	localparam int PGS_LIN_WIN = 5;
	localparam int PGS_BUCK_WIN = 4;
	localparam logic [7:0] PGM_WMASK = 8'h01;
	localparam int PGM_MODE = 0;
	localparam int PGI_BIT = 7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// delay step sizes in microseconds
	localparam int unsigned STEP_SHORT_US = 500;
	localparam int unsigned STEP_LONG_US = 1000;
	localparam int unsigned STEP_SHORT_CYC = (CLK_HZ / 1000000) * STEP_SHORT_US;
	localparam int unsigned STEP_LONG_CYC = (CLK_HZ / 1000000) * STEP_LONG_US;
	localparam int DLY_W = 20;
	typedef enum logic [1:0] {DS_IDLE, DS_RUN, DS_DONE} pcg_dly_state_type;
endpackage

// ### verification/pcg_config_props.sv
// Purpose: port-level checks of the configuration bank
// Assumes: register copies land one cycle after the strobe
// Notes: written data is kept one cycle in a helper flop for comparison
`timescale 1ns/1ps
`default_nettype none
module pcg_config_props
	import pcg_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_ack_o,
	input wire logic spread_spectrum_enable_o,
	input wire logic pll_enable_o,
	input wire logic use_external_clock_o,
	input wire logic [4:0] external_clock_frequency_code_o,
	input wire logic power_good_out_o,
	input wire logic power_good_out_oe_n_o,
	input wire logic power_good_operating_mode_o,
	input wire logic power_good_fall_interrupt_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic [7:0] wd_ff;
	// last write data, so copies can be compared without a sliced past value
	always_ff @(posedge clock_i)
		wd_ff <= reg_wdata_i;
	chk_ack_follows: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o) else $error("ack missing");
	chk_ack_idle: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o) else $error("stray ack");
	chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > ADDR_PG_INT |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_spread_copy: assert property (reg_wr_i && reg_addr_i == ADDR_OPTIONS
		|=> spread_spectrum_enable_o == wd_ff[OPT_SPREAD]) else $error("spread copy wrong");
	chk_pll_copy: assert property (reg_wr_i && reg_addr_i == ADDR_EXT_CLK
		|=> pll_enable_o == wd_ff[EXT_PLL_EN]) else $error("pll copy wrong");
	chk_freq_copy: assert property (reg_wr_i && reg_addr_i == ADDR_EXT_CLK
		|=> external_clock_frequency_code_o == wd_ff[4:0]) else $error("frequency code wrong");
	chk_pll_off: assert property (!pll_enable_o && !$past(pll_enable_o) |-> !use_external_clock_o)
		else $error("external clock used with pll off");
	chk_mode_copy: assert property (reg_wr_i && reg_addr_i == ADDR_PG_MODE
		|=> power_good_operating_mode_o == wd_ff[PGM_MODE]) else $error("mode copy wrong");
	chk_int_sticky: assert property (power_good_fall_interrupt_o && !(reg_wr_i && reg_addr_i == ADDR_PG_INT
		&& reg_wdata_i[PGI_BIT]) |=> power_good_fall_interrupt_o) else $error("interrupt lost");
	chk_low_driven: assert property (!power_good_out_o |-> !power_good_out_oe_n_o)
		else $error("low level not driven");
endmodule
bind pcg_config pcg_config_props pcg_config_props_inst (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
	.reg_wdata_i, .reg_rdata_o, .reg_ack_o, .spread_spectrum_enable_o, .pll_enable_o, .use_external_clock_o,
	.external_clock_frequency_code_o, .power_good_out_o, .power_good_out_oe_n_o, .power_good_operating_mode_o,
	.power_good_fall_interrupt_o);
`default_nettype wire

// ### verification/pcg_config_test.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: delay steps shortened to 4 and 8 cycles
// Notes: delay checks use differences so fixed pipeline offsets cancel
`timescale 1ns/1ps
`default_nettype none
module pcg_config_test
	import pcg_pkg::*;
;
	localparam int unsigned SC = 4;
	localparam int unsigned LC = 8;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
	logic reg_wr_i, reg_rd_i, reg_ack_o, enable_pin_i = 1'b0, ext_clk_present_i = 1'b0;
	logic [3:0] source_uv_ok_i = 4'hf, source_ov_ok_i = 4'hf, startup_code_i = 4'h3, shutdown_code_i = 4'h5;
	logic startup_done_o, shutdown_done_o, clock_pin_is_input_o, clock_pin_pulldown_o, enable_pin_pulldown_o;
	logic thermal_warning_threshold_o, spread_spectrum_enable_o, pll_enable_o, use_external_clock_o;
	logic [4:0] external_clock_frequency_code_o;
	logic ext_clock_event_o, power_good_out_o, power_good_out_oe_n_o, power_good_operating_mode_o;
	logic power_good_fall_interrupt_o;
	int num_errors = 0, compares = 0, cyc = 0, evn = 0;
	pcg_config #(.SHORT_CYC(SC), .LONG_CYC(LC)) pcg_config_inst (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i,
		.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .enable_pin_i, .ext_clk_present_i, .source_uv_ok_i,
		.source_ov_ok_i, .startup_code_i, .shutdown_code_i, .general_output_2_level_i(1'b0), .startup_done_o,
		.shutdown_done_o, .clock_pin_is_input_o, .clock_pin_pulldown_o, .enable_pin_pulldown_o,
		.thermal_warning_threshold_o, .spread_spectrum_enable_o, .pll_enable_o, .use_external_clock_o,
		.external_clock_frequency_code_o, .ext_clock_event_o, .power_good_out_o, .power_good_out_oe_n_o,
		.power_good_operating_mode_o, .power_good_fall_interrupt_o);
	pcg_host pcg_host_inst (.clock_i, .rdata_i(reg_rdata_o), .ack_i(reg_ack_o), .addr_o(reg_addr_i),
		.wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
	// 25 MHz core clock
	always #20 clock_i = ~clock_i;
	// event counter and hang guard, well above the few hundred cycles the tests need
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (ext_clock_event_o === 1'b1)
			evn <= evn + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			end_sim();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		pcg_host_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		pcg_host_inst.xfer(1'b0, a, 8'h00, q);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// bounded wait for a flag, counted in whole clock cycles at the falling edge
	task automatic wfor(ref logic s, output int n);
		n = 0;
		@(negedge clock_i);
		while (s !== 1'b1 && n < 300)
		begin
			@(negedge clock_i);
			n++;
		end
		// a flag that never comes counts against the run
		if (n >= 300)
		begin
			num_errors++;
			$display("unexpected wait limit expected flag seen none");
		end
	endtask
	task automatic t_reset();
		logic [7:0] ad [6];
		ad = '{ADDR_OPTIONS, ADDR_EXT_CLK, ADDR_PG_SRC, ADDR_PG_MODE, ADDR_PG_INT, 8'h30};
		foreach (ad[i])
		begin
			rd(ad[i]);
			check("reset read", q, 8'h00);
		end
		$display("test reset done");
	endtask
	task automatic t_options();
		logic [7:0] v [3];
		v = '{8'hff, 8'h09, 8'h16};
		foreach (v[i])
		begin
			wr(ADDR_OPTIONS, v[i]);
			rd(ADDR_OPTIONS);
			check("options", q, v[i] & OPT_WMASK);
			check("option pins", {3'h0, clock_pin_is_input_o, clock_pin_pulldown_o, enable_pin_pulldown_o,
				thermal_warning_threshold_o, spread_spectrum_enable_o}, {3'h0, v[i][4:0]});
		end
		$display("test options done");
	endtask
	task automatic t_delay();
		int s [2];
		int d [2];
		for (int r = 0; r < 2; r++)
		begin
			wr(ADDR_OPTIONS, r ? 8'h60 : 8'h00);
			@(posedge clock_i);
			enable_pin_i <= 1'b1;
			wfor(startup_done_o, s[r]);
			@(posedge clock_i);
			enable_pin_i <= 1'b0;
			wfor(shutdown_done_o, d[r]);
		end
		check("startup step", 8'(s[1] - s[0]), 8'(3 * (LC - SC)));
		check("shutdown step", 8'(d[1] - d[0]), 8'(5 * (LC - SC)));
		$display("test delay done");
	endtask
	task automatic t_ext();
		int n, e;
		wr(ADDR_OPTIONS, 8'h10);
		wr(ADDR_EXT_CLK, 8'hf7);
		rd(ADDR_EXT_CLK);
		check("ext clock reg", q, 8'h57);
		check("freq code", external_clock_frequency_code_o, 8'h17);
		e = evn;
		@(posedge clock_i);
		ext_clk_present_i <= 1'b1;
		wfor(use_external_clock_o, n);
		check("use external", use_external_clock_o, 8'h01);
		@(posedge clock_i);
		ext_clk_present_i <= 1'b0;
		waitc(8);
		check("clock events", 8'(evn - e), 8'h02);
		check("fell back", use_external_clock_o, 8'h00);
		wr(ADDR_EXT_CLK, 8'h17);
		@(posedge clock_i);
		ext_clk_present_i <= 1'b1;
		waitc(8);
		check("pll off", {pll_enable_o, use_external_clock_o}, 8'h00);
		check("no events", 8'(evn - e), 8'h02);
		// pll on with the clock present, but the pin left as general output
		wr(ADDR_OPTIONS, 8'h00);
		wr(ADDR_EXT_CLK, 8'h57);
		waitc(4);
		check("pin as output", use_external_clock_o, 8'h00);
		$display("test ext clock done");
	endtask
	// set the supply status, program the sources, then judge pin level and drive enable
	task automatic pg(input logic [7:0] src, input logic [3:0] uv, input logic [3:0] ov, input logic [1:0] exp);
		@(posedge clock_i);
		source_uv_ok_i <= uv;
		source_ov_ok_i <= ov;
		wr(ADDR_PG_SRC, src);
		waitc(4);
		@(negedge clock_i);
		check("power good pin", {power_good_out_o, power_good_out_oe_n_o}, exp);
	endtask
	task automatic t_power_good_out();
		wr(ADDR_PG_MODE, 8'h01);
		pg(8'h01, 4'hf, 4'hf, 2'h2);
		pg(8'h01, 4'he, 4'hf, 2'h0);
		pg(8'h01, 4'hf, 4'hf, 2'h2);
		check("fall interrupt", power_good_fall_interrupt_o, 8'h01);
		rd(ADDR_PG_INT);
		check("interrupt reg", q, 8'h80);
		wr(ADDR_PG_INT, 8'h80);
		check("cleared", power_good_fall_interrupt_o, 8'h00);
		pg(8'h01, 4'hf, 4'he, 2'h2);
		pg(8'h11, 4'hf, 4'he, 2'h0);
		pg(8'h21, 4'hf, 4'hb, 2'h2);
		pg(8'h25, 4'hf, 4'hb, 2'h0);
		pg(8'h05, 4'hf, 4'hb, 2'h2);
		pg(8'h01, 4'hd, 4'hf, 2'h2);
		pg(8'h81, 4'hf, 4'hf, 2'h0);
		pg(8'hc1, 4'hf, 4'hf, 2'h0);
		pg(8'hc1, 4'he, 4'hf, 2'h3);
		wr(ADDR_PG_MODE, 8'h00);
		pg(8'h01, 4'hf, 4'hf, 2'h0);
		@(posedge clock_i);
		enable_pin_i <= 1'b1;
		waitc(6);
		@(negedge clock_i);
		check("gated on", power_good_out_o, 8'h01);
		$display("test power good done");
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// reset for five cycles, then the scenarios in turn
	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset();
		t_options();
		t_delay();
		t_ext();
		t_power_good_out();
		end_sim();
	end
endmodule
`default_nettype wire

// ### verification/pcg_host.sv
// Purpose: host side of the register port
// Assumes: strobes are one-cycle pulses, answer one cycle later
// Notes: a missing answer returns unknown so the caller's compare fails
`timescale 1ns/1ps
`default_nettype none
module pcg_host
	import pcg_pkg::*;
(
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	input wire logic ack_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// idle bus from time zero
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// one strobe pulse; the answer is taken where it has settled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= (a == ADDR_EXT_CLK) ? (d & 8'hdf) : d;
		wr_o <= w;
		rd_o <= !w;
		@(posedge clock_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		@(negedge clock_i);
		q = (ack_i === 1'b1) ? rdata_i : 8'hxx;
	endtask
endmodule
`default_nettype wire
